// file: hdl/epsa_port.sv
// eight-bit general purpose port with peripheral sharing on six pins
// assumes pad cells resolve pin level from out/oe/pull; oe is active low
`timescale 1ns/1ns
module epsa_port
  import epsa_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // register port
  input  wire logic [15:0]      addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [7:0]       rdata_o,
  // pins
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_n_o,
  output logic      [WIDTH-1:0] pullup_o,
  // peripheral side
  input  wire logic [WIDTH-1:0] alt_out_i,
  output logic      [WIDTH-1:0] alt_in_o
);

  if (WIDTH != 8) begin : g_chk
    $error("epsa_port supports only an eight-bit port");
  end

  // decoded register, shared by the write path and the read path
  typedef enum logic [2:0] {
    EPSA_R_NONE,
    EPSA_R_LATCH,
    EPSA_R_INPUT,
    EPSA_R_DIR,
    EPSA_R_FUNC,
    EPSA_R_OTYPE,
    EPSA_R_PULL
  } epsa_reg_t;

  function automatic epsa_reg_t epsa_sel(input logic [15:0] addr);
    epsa_reg_t hit;
    hit = EPSA_R_NONE;
    if (addr == EPSA_OFS_LATCH) begin
      hit = EPSA_R_LATCH;
    end else if (addr == EPSA_OFS_INPUT) begin
      hit = EPSA_R_INPUT;
    end else if (addr == EPSA_OFS_DIR) begin
      hit = EPSA_R_DIR;
    end else if (addr == EPSA_OFS_FUNC) begin
      hit = EPSA_R_FUNC;
    end else if (addr == EPSA_OFS_OTYPE) begin
      hit = EPSA_R_OTYPE;
    end else if (addr == EPSA_OFS_PULLUP) begin
      hit = EPSA_R_PULL;
    end
    return hit;
  endfunction

  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] func_q;
  logic [7:0] otype_q;
  logic [7:0] pull_q;
  logic [7:0] pin_sync;
  logic [7:0] src_d;
  logic [7:0] drive_n_d;
  logic [7:0] pull_d;
  logic [7:0] alt_d;
  logic [7:0] rdata_d;
  logic [7:0] readback;
  epsa_reg_t  reg_sel;

  epsa_sync #(
    .WIDTH (8)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  );

  assign reg_sel = epsa_sel(addr_i);

  // register writes; unmapped writes are ignored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= EPSA_RST_VAL;
      dir_q   <= EPSA_RST_VAL;
      func_q  <= EPSA_RST_VAL;
      otype_q <= EPSA_RST_VAL;
      pull_q  <= EPSA_RST_VAL;
    end else if (wr_i) begin
      // the input readback has no storage, so its writes fall to default
      case (reg_sel)
        EPSA_R_LATCH: begin
          latch_q <= wdata_i; // [RULE2]
        end
        EPSA_R_DIR: begin
          dir_q <= wdata_i; // [RULE1] [RULE4]
        end
        EPSA_R_FUNC: begin
          func_q <= wdata_i & EPSA_FUNC_MASK; // [RULE5]
        end
        EPSA_R_OTYPE: begin
          otype_q <= wdata_i & EPSA_OTYPE_MASK; // [RULE6]
        end
        EPSA_R_PULL: begin
          pull_q <= wdata_i & EPSA_PULL_MASK; // [RULE7]
        end
        default: begin
        end
      endcase
    end
  end

  // open-drain bits show the pin too, since software reads the wired-and level;
  // bus pins under their peripheral are open-drain as well
  assign readback = pin_sync & (~dir_q | otype_q | (EPSA_BUS_PINS & func_q)); // [RULE10]

  // pin drive: bus pins (4,3) have no type bit, so with the peripheral on they are
  // always open-drain to let the far end pull the line low
  always_comb begin
    src_d     = (latch_q & ~func_q) | (alt_out_i & func_q); // [RULE5]
    drive_n_d = 8'hFF;
    pull_d    = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (dir_q[i]) begin
        if (EPSA_BUS_PINS[i] && func_q[i]) begin
          drive_n_d[i] = src_d[i]; // [RULE8]
        end else if (otype_q[i]) begin
          drive_n_d[i] = src_d[i]; // [RULE3]
          pull_d[i]    = pull_q[i]; // [RULE7]
        end else begin
          drive_n_d[i] = 1'b0; // [RULE2] [RULE3]
        end
      end else begin
        pull_d[i] = pull_q[i]; // [RULE7]
      end
    end
    // input side feeds peripherals; bus pins under their peripheral also listen while outputs
    alt_d = pin_sync & (~dir_q | (EPSA_BUS_PINS & func_q)); // [RULE4] [RULE8]
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o      <= '0;
      pin_oe_n_o <= '1;
      pullup_o   <= '0;
      alt_in_o   <= '0;
    end else begin
      pin_o      <= src_d & ~drive_n_d;
      pin_oe_n_o <= drive_n_d;
      pullup_o   <= pull_d;
      alt_in_o   <= alt_d;
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_sel)
      EPSA_R_LATCH: begin
        rdata_d = latch_q; // [RULE11]
      end
      EPSA_R_INPUT: begin
        rdata_d = readback; // [RULE10]
      end
      EPSA_R_DIR: begin
        rdata_d = dir_q;
      end
      EPSA_R_FUNC: begin
        rdata_d = func_q;
      end
      EPSA_R_OTYPE: begin
        rdata_d = otype_q;
      end
      EPSA_R_PULL: begin
        rdata_d = pull_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  a_latch_rdback : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    (rd_i && addr_i == EPSA_OFS_LATCH) |=> rdata_o == $past(latch_q))
    else $error("latch readback differs from stored latch");

  a_func_upper0 : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    func_q[7:6] == 2'b00)
    else $error("function bits 7 and 6 not zero");

  a_otype_mid0 : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    otype_q[4:3] == 2'b00)
    else $error("output type bits 4 and 3 not zero");

  a_pull_mid0 : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    pull_q[4:3] == 2'b00)
    else $error("pull-up bits 4 and 3 not zero");

  a_pushpull_drv : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    (dir_q[7] && !otype_q[7] && !func_q[7] && $stable(dir_q) && $stable(otype_q))
    |=> (!pin_oe_n_o[7] && pin_o[7] == $past(latch_q[7])))
    else $error("push-pull pin does not follow latch");

  a_input_float : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    (!dir_q[0]) |=> pin_oe_n_o[0])
    else $error("input pin is driven");

  a_od_high_float : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    (dir_q[2] && otype_q[2] && !func_q[2] && latch_q[2]) |=> pin_oe_n_o[2])
    else $error("open-drain one is driven");

  a_pull_gate : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    (dir_q[5] && !otype_q[5]) |=> !pullup_o[5])
    else $error("pull-up on in push-pull mode");

  a_rd_pushpull0 : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    (rd_i && addr_i == EPSA_OFS_INPUT && dir_q[6] && !otype_q[6]) |=> !rdata_o[6])
    else $error("push-pull bit reads nonzero");

  a_bus_od : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    (dir_q[4] && func_q[4] && alt_out_i[4]) |=> pin_oe_n_o[4])
    else $error("bus clock line driven high");

  a_rd_idle_zero : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    !rd_i
    |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  a_dir_rdback : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    (rd_i && addr_i == EPSA_OFS_DIR)
    |=> rdata_o == $past(dir_q))
    else $error("direction readback differs");

  a_func_rdback : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    (rd_i && addr_i == EPSA_OFS_FUNC)
    |=> rdata_o == $past(func_q))
    else $error("function readback differs");

  a_otype_rdback : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    (rd_i && addr_i == EPSA_OFS_OTYPE)
    |=> rdata_o == $past(otype_q))
    else $error("output type readback differs");

  a_pull_rdback : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    (rd_i && addr_i == EPSA_OFS_PULLUP)
    |=> rdata_o == $past(pull_q))
    else $error("pull-up readback differs");

  a_rd_input_pin : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    (rd_i && addr_i == EPSA_OFS_INPUT && !dir_q[1])
    |=> rdata_o[1] == $past(pin_sync[1]))
    else $error("input pin readback differs");

  a_rd_od_pin : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    (rd_i && addr_i == EPSA_OFS_INPUT && dir_q[2] && otype_q[2])
    |=> rdata_o[2] == $past(pin_sync[2]))
    else $error("open-drain pin readback differs");

  a_rd_bus_pin : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8] [RULE10]
    (rd_i && addr_i == EPSA_OFS_INPUT && dir_q[4] && func_q[4])
    |=> rdata_o[4] == $past(pin_sync[4]))
    else $error("bus pin readback differs");

  a_latch_write : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    (wr_i && addr_i == EPSA_OFS_LATCH)
    |=> latch_q == $past(wdata_i))
    else $error("latch write lost");

  a_dir_write : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    (wr_i && addr_i == EPSA_OFS_DIR)
    |=> dir_q == $past(wdata_i))
    else $error("direction write lost");

  a_func_write : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    (wr_i && addr_i == EPSA_OFS_FUNC)
    |=> func_q == ($past(wdata_i) & EPSA_FUNC_MASK))
    else $error("function write lost");

  a_otype_write : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    (wr_i && addr_i == EPSA_OFS_OTYPE)
    |=> otype_q == ($past(wdata_i) & EPSA_OTYPE_MASK))
    else $error("output type write lost");

  a_pull_write : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    (wr_i && addr_i == EPSA_OFS_PULLUP)
    |=> pull_q == ($past(wdata_i) & EPSA_PULL_MASK))
    else $error("pull-up write lost");

  a_od_low_drive : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2] [RULE3]
    (dir_q[0] && otype_q[0] && !func_q[0] && !latch_q[0])
    |=> (!pin_oe_n_o[0] && !pin_o[0]))
    else $error("open-drain zero not driven low");

  a_pp_high_drive : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    (dir_q[1] && !otype_q[1] && !func_q[1] && latch_q[1])
    |=> (!pin_oe_n_o[1] && pin_o[1]))
    else $error("push-pull one not driven high");

  a_alt_route : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    (dir_q[5] && func_q[5] && !otype_q[5])
    |=> (!pin_oe_n_o[5] && pin_o[5] == $past(alt_out_i[5])))
    else $error("peripheral output not routed");

  a_uart_route : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    (dir_q[1] && func_q[1] && !otype_q[1])
    |=> (!pin_oe_n_o[1] && pin_o[1] == $past(alt_out_i[1])))
    else $error("uart output not routed");

  a_od_alt_release : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    (dir_q[0] && func_q[0] && otype_q[0] && alt_out_i[0])
    |=> pin_oe_n_o[0])
    else $error("open-drain peripheral one is driven");

  a_bus_low_drive : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    (dir_q[3] && func_q[3] && !alt_out_i[3])
    |=> (!pin_oe_n_o[3] && !pin_o[3]))
    else $error("bus data line not pulled low");

  a_input_pull : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    !dir_q[2]
    |=> pullup_o[2] == $past(pull_q[2]))
    else $error("input pull-up does not follow enable");

  a_od_pull : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    (dir_q[7] && otype_q[7])
    |=> pullup_o[7] == $past(pull_q[7]))
    else $error("open-drain pull-up does not follow enable");

  a_alt_in_input : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    !dir_q[0]
    |=> alt_in_o[0] == $past(pin_sync[0]))
    else $error("input pin not fed to peripheral");

  a_alt_in_quiet : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    dir_q[6]
    |=> !alt_in_o[6])
    else $error("output pin fed to peripheral");

  a_bus_listen : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    (dir_q[3] && func_q[3])
    |=> alt_in_o[3] == $past(pin_sync[3]))
    else $error("bus line level not fed back");

  a_dir_indep : assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    (!dir_q[1] && dir_q[0] && !otype_q[0] && !func_q[0])
    |=> (pin_oe_n_o[1] && !pin_oe_n_o[0]))
    else $error("pin directions not independent");
endmodule

// file: hdl/epsa_pkg.sv
// register map, field masks and reset values of the eight-bit port
// assumes byte-wide registers reached over the plain register port
// Functional notes
// RULE1 - the port has eight pins and each pin direction is chosen alone.
// RULE2 - the output latch holds one bit per pin, resets to zero, and a zero drives an output low.
// RULE3 - a latch one drives high in push-pull, and floats or is pulled up in open-drain.
// RULE4 - the direction register resets to zero, zero is input feeding port and peripheral, one is output.
// RULE5 - the function register holds bits 5 to 0, zero selects latch, one selects peripheral, bits 7 and 6 read zero.
// RULE6 - the output-type register holds bits 7 to 5 and 2 to 0, zero is push-pull, one is open-drain.
// RULE7 - a pull-up bit connects only for input mode or open-drain output, and bits 4 and 3 read zero.
// RULE8 - bits 4 and 3 act as two-way bus clock and data lines, bits 1 and 0 carry uart signals.
// RULE9 - software also programs the separate serial selection logic before using a serial pin.
// RULE10 - the input readback returns the pin for input or open-drain bits and zero for push-pull outputs.
// RULE11 - reading the output latch returns the stored values, not the pin levels.
package epsa_pkg;
  localparam logic [15:0] EPSA_OFS_LATCH  = 16'h0002;
  localparam logic [15:0] EPSA_OFS_INPUT  = 16'h000F;
  localparam logic [15:0] EPSA_OFS_DIR    = 16'h0F1C;
  localparam logic [15:0] EPSA_OFS_PULLUP = 16'h0F29;
  localparam logic [15:0] EPSA_OFS_FUNC   = 16'h0F36;
  localparam logic [15:0] EPSA_OFS_OTYPE  = 16'h0F43;
  localparam logic [7:0]  EPSA_RST_VAL    = 8'h00;
  localparam logic [7:0]  EPSA_FUNC_MASK  = 8'h3F;
  localparam logic [7:0]  EPSA_OTYPE_MASK = 8'hE7;
  localparam logic [7:0]  EPSA_PULL_MASK  = 8'hE7;
  localparam logic [7:0]  EPSA_BUS_PINS   = 8'h18;
endpackage

// file: hdl/epsa_sync.sv
// three-stage synchroniser with agreement filter for the pin inputs
// assumes pins are asynchronous to clk_i
`timescale 1ns/1ns
module epsa_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// file: bench/epsa_pin_model.sv
// pads and far-side drivers of the eight pins
// assumes oe is active low and the far side yields to the port
`timescale 1ns/1ns
module epsa_pin_model (
  // port side
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] pull_i,
  // far side
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pin_lvl_o
);
  logic [7:0] flip_q = 8'h00;
  always @(posedge clk_i) begin
    flip_q <= ~flip_q;
  end
  // a floating pin wanders unless pulled up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_lvl_o[i] = !oe_n_i[i] ? drv_i[i] : ext_en_i[i] ? ext_i[i] : pull_i[i] | flip_q[i];
    end
  end
endmodule

// file: bench/test_eight_bit_port_with_serial_alt_functions.sv
// self-checking bench of the port against a register and pin model
// assumes registered outputs settle within eight cycles of a change
`timescale 1ns/1ns
module test_eight_bit_port_with_serial_alt_functions;
  import epsa_pkg::*;
  logic        clk_i, rst_i, wr_i, rd_i;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i, rdata_o, pin_i, pin_o, oe_n, pull, alt_out_i, alt_in_o, ext, v;
  logic [7:0]  m_lat, m_dir, m_pu, m_fc, m_ot, e_pin, e_oe, od, src, lvl, ext_en, ep, kn, am;
  int          fails = 0;
  int          cmp_count = 0;
  epsa_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(oe_n), .pullup_o(pull), .alt_out_i(alt_out_i), .alt_in_o(alt_in_o));
  epsa_pin_model pm_u (.clk_i(clk_i), .drv_i(pin_o), .oe_n_i(oe_n), .pull_i(pull),
    .ext_i(ext), .ext_en_i(ext_en), .pin_lvl_o(pin_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    case (a)
      EPSA_OFS_LATCH: m_lat = d;
      EPSA_OFS_DIR: m_dir = d;
      EPSA_OFS_PULLUP: m_pu = d & EPSA_PULL_MASK;
      EPSA_OFS_FUNC: m_fc = d & EPSA_FUNC_MASK;
      EPSA_OFS_OTYPE: m_ot = d & EPSA_OTYPE_MASK;
      default: ;
    endcase
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] msk = 8'hFF);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & msk, exp & msk);
  endtask
  task automatic regs();
    rc(EPSA_OFS_LATCH, m_lat);
    rc(EPSA_OFS_DIR, m_dir);
    rc(EPSA_OFS_PULLUP, m_pu);
    rc(EPSA_OFS_FUNC, m_fc);
    rc(EPSA_OFS_OTYPE, m_ot);
  endtask
  task automatic pins();
    repeat (8) @(posedge clk_i);
    #1;
    od = m_ot | (m_fc & EPSA_BUS_PINS);
    src = (m_fc & alt_out_i) | (~m_fc & m_lat);
    e_oe = ~m_dir | (od & src);
    e_pin = m_dir & ~od & src;
    // undriven, unpulled pins with no far-side driver wander: leave them out
    ep = m_pu & (~m_dir | od);
    kn = ~e_oe | ext_en | ep;
    lvl = (~e_oe & e_pin) | (e_oe & ext_en & ext) | (e_oe & ~ext_en & ep);
    am = (~m_dir | (m_fc & EPSA_BUS_PINS)) & kn;
    chk(pin_o, e_pin);
    chk(oe_n, e_oe);
    chk(pull, ep);
    chk(alt_in_o & am, lvl & am);
    rc(EPSA_OFS_INPUT, lvl & (~m_dir | od), kn);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {rst_i, wr_i, rd_i} = 3'b100;
    {addr_i, wdata_i, alt_out_i} = '0;
    {m_lat, m_dir, m_pu, m_fc, m_ot} = '0;
    ext = 8'h5A;
    ext_en = 8'hFF;
    void'($urandom(70));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    regs();
    pins();
    $display("test reset done");
    put(EPSA_OFS_PULLUP, 8'hFF);
    put(EPSA_OFS_FUNC, 8'hFF);
    put(EPSA_OFS_OTYPE, 8'hFF);
    put(EPSA_OFS_INPUT, 8'hFF);
    put(16'h0010, 8'hFF);
    rc(16'h0010, 8'h00);
    regs();
    $display("test reserved bits done");
    // random settings cross every mode, including shared bus pins
    for (int n = 0; n < 60; n++) begin
      @(posedge clk_i);
      ext <= 8'($urandom);
      ext_en <= 8'($urandom);
      alt_out_i <= 8'($urandom);
      put(EPSA_OFS_LATCH, 8'($urandom));
      // direction goes ahead of the function bits; selection logic is outside
      put(EPSA_OFS_DIR, 8'($urandom));
      put(EPSA_OFS_PULLUP, 8'($urandom));
      put(EPSA_OFS_OTYPE, 8'($urandom));
      put(EPSA_OFS_FUNC, (n < 20) ? 8'h00 : 8'($urandom));
      regs();
      pins();
    end
    $display("test random modes done");
    end_sim();
  end
endmodule
